// *** verilog/adc_ctrl_pkg.sv ***
// Register map, field layout, reset values and timing constants of the converter control
package adc_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] IDX_PORT_A_PINS   = 8'h05;
  localparam logic [7:0] IDX_INTR_CONTROL  = 8'h0B;
  localparam logic [7:0] IDX_PERIPH_FLAGS  = 8'h0C;
  localparam logic [7:0] IDX_CONV_RESULT   = 8'h1E;
  localparam logic [7:0] IDX_CONV_CTRL0    = 8'h1F;
  localparam logic [7:0] IDX_PORT_A_DIR    = 8'h85;
  localparam logic [7:0] IDX_PERIPH_ENABLE = 8'h8C;
  localparam logic [7:0] IDX_CONV_CTRL1    = 8'h9F;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTL0_CLK_LSB  = 6;   // conv_clock_select, two bits
  localparam int CTL0_CHAN_LSB = 3;   // channel_select, three bits
  localparam int CTL0_GO       = 2;   // conversion in progress
  localparam int CTL0_POWER    = 0;   // converter_power
  localparam int FLAG_CONV     = 6;   // converter_irq_flag / converter_irq_enable
  localparam int PORT_W        = 5;   // implemented port pins
  localparam int ANALOG_W      = 4;   // pins that can be analog inputs

  // ---------------------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTL0_RST   = 8'h00;
  localparam logic [7:0] CTL1_RST   = 8'h00;
  localparam logic [7:0] DIR_RST    = 8'h1F;
  localparam logic [7:0] INTC_RST   = 8'h00;
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;

  // ---------------------------------------------------------------------------
  // Conversion clock half periods in system clocks; sequence timing counted in half conversion-clock periods
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SEL_2TOSC   = 2'h0;
  localparam logic [1:0] SEL_8TOSC   = 2'h1;
  localparam logic [1:0] SEL_32TOSC  = 2'h2;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         RC_TAD_NS     = 4000;           // Typical internal RC period
  localparam logic [7:0] HALF_2TOSC  = 8'h01;
  localparam logic [7:0] HALF_8TOSC  = 8'h04;
  localparam logic [7:0] HALF_32TOSC = 8'h10;
  localparam logic [7:0] HALF_RC     = 8'(RC_TAD_NS / (2 * CLK_PERIOD_NS));
  localparam logic [4:0] CONV_HALVES   = 5'h13;          // 9.5 periods
  localparam logic [4:0] FIRST_RESOLVE = 5'h02;
  localparam logic [4:0] LAST_RESOLVE  = 5'h10;
  localparam logic [7:0] MSB_TRIAL     = 8'h80;
  localparam logic [3:0] CAPCOMP_ADC_TRIG = 4'hB;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } conv_state_t;

endpackage

// *** verilog/adc_conversion_control.sv ***
// Converter control: register slave, conversion clock, successive-approximation sequencer
// Notes on behaviour
// - Finish loads result, clears busy, sets flag
// - Result register never reset
// - Conversion lasts 9.5 conversion-clock periods
// - Clock select: 2, 8, 32 osc, RC
// - Mode 1011 trigger starts conversion, clears timer
// - Unpowered: trigger ignored, timer still cleared
// - Output pin converts its own driven level
// - Channel and direction never block conversion
// - Analog pins read zero from port
// - Digital input pins still get converted
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control
  import adc_ctrl_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              CLK_SYS,
  input  wire logic              RSTN,
  input  wire logic              CE,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [PORT_W-1:0] PORT_A_IN,
  output logic      [PORT_W-1:0] PORT_A_OUT,
  output logic      [PORT_W-1:0] PORT_A_OE,
  input  wire logic [3:0]        CAPCOMP_MODE,
  input  wire logic              SPECIAL_EVENT,
  input  wire logic              CMP_ABOVE,
  output logic      [2:0]        CHANNEL_SEL,
  output logic      [7:0]        DAC_CODE,
  output logic                   SAMPLE_HOLD,
  output logic                   CONV_BUSY,
  output logic                   TIMER1_CLEAR
);

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [1:0]          clk_sel_q;
  logic [2:0]          chan_q;
  logic                go_q, go_d;
  logic                power_q;
  logic [2:0]          port_cfg_q;
  logic [PORT_W-1:0]   latch_q;
  logic [PORT_W-1:0]   oe_q;
  logic [7:0]          intc_q;
  logic [3:0]          flags_q;        // Bit 3 is converter_irq_flag, bits 2:0 storage
  logic                flag_d;
  logic [3:0]          enable_q;
  logic [7:0]          result_q;
  logic [31:0]         prdata_q;
  logic                pready_q, pslverr_q, timer_clr_q;

  // Sequencer state
  conv_state_t st_q;
  logic [7:0]  div_q, half_q, half_sel;
  logic [4:0]  hc_q;
  logic [7:0]  sar_q, mask_q;
  logic        tick, resolve, finish, evt_start;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic [7:0]          idx;
  logic                aligned, mapped, setup_acc, done_acc, wr;
  logic [7:0]          rd_byte;
  logic [ANALOG_W-1:0] analog_mask;

  assign idx       = PADDR[9:2];
  assign aligned   = (PADDR[1:0] == 2'h0) && (PADDR[ADDR_W-1:10] == '0);
  assign setup_acc = PSEL && PENABLE && !pready_q;
  assign done_acc  = PSEL && PENABLE && pready_q;
  assign wr        = CE && done_acc && PWRITE && mapped;

  // Analog pin map; every configuration listed leaves at least the channel mux working
  always_comb begin
    case (port_cfg_q)
      3'h4, 3'h5: analog_mask = 4'h3;
      3'h6, 3'h7: analog_mask = 4'h0;
      default:    analog_mask = 4'hF;
    endcase
  end

  // Read multiplexer; analog pins read as low whatever the pin level
  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    if (!aligned) begin
      mapped = 1'b0;
    end else begin
      case (idx)
        IDX_PORT_A_PINS:   rd_byte = {3'h0, PORT_A_IN & ~{1'b0, analog_mask}};
        IDX_INTR_CONTROL:  rd_byte = intc_q;
        IDX_PERIPH_FLAGS:  rd_byte = {1'b0, flags_q[3], 3'h0, flags_q[2:0]};
        IDX_CONV_RESULT:   rd_byte = result_q;
        IDX_CONV_CTRL0:    rd_byte = {clk_sel_q, chan_q, go_q, 1'b0, power_q};
        IDX_PORT_A_DIR:    rd_byte = {3'h0, ~oe_q};
        IDX_PERIPH_ENABLE: rd_byte = {1'b0, enable_q[3], 3'h0, enable_q[2:0]};
        IDX_CONV_CTRL1:    rd_byte = {5'h00, port_cfg_q};
        default:           mapped  = 1'b0;
      endcase
    end
  end

  // Answer one cycle into the access phase; unmapped words read zero with an error
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (CE) begin
      pready_q  <= setup_acc;
      pslverr_q <= setup_acc && !mapped;
      if (setup_acc && !PWRITE) begin
        prdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Plain storage registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      clk_sel_q  <= CTL0_RST[7:6];
      chan_q     <= CTL0_RST[5:3];
      power_q    <= CTL0_RST[CTL0_POWER];
      port_cfg_q <= CTL1_RST[2:0];
      latch_q    <= '0;
      oe_q       <= ~DIR_RST[PORT_W-1:0];
      intc_q     <= INTC_RST;
      enable_q   <= {ENABLE_RST[FLAG_CONV], ENABLE_RST[2:0]};
    end else if (wr) begin
      case (idx)
        IDX_CONV_CTRL0: begin
          clk_sel_q <= PWDATA[CTL0_CLK_LSB +: 2];
          chan_q    <= PWDATA[CTL0_CHAN_LSB +: 3];
          power_q   <= PWDATA[CTL0_POWER];
        end
        IDX_CONV_CTRL1:    port_cfg_q <= PWDATA[2:0];
        IDX_PORT_A_PINS:   latch_q    <= PWDATA[PORT_W-1:0];
        IDX_PORT_A_DIR:    oe_q       <= ~PWDATA[PORT_W-1:0];
        IDX_INTR_CONTROL:  intc_q     <= PWDATA[7:0];
        IDX_PERIPH_ENABLE: enable_q   <= {PWDATA[FLAG_CONV], PWDATA[2:0]};
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Start bit and completion flag
  // ---------------------------------------------------------------------------
  // Old power state qualifies a software start, so a write that powers up cannot start
  assign evt_start = SPECIAL_EVENT && (CAPCOMP_MODE == CAPCOMP_ADC_TRIG) && power_q;

  always_comb begin
    go_d = go_q;
    if (finish) begin
      go_d = 1'b0;
    end
    if (wr && idx == IDX_CONV_CTRL0) begin
      go_d = PWDATA[CTL0_GO] && PWDATA[CTL0_POWER] && power_q;
    end
    if (evt_start) begin
      go_d = 1'b1;
    end
  end

  // Flag set by hardware wins over a clearing write in the same cycle
  always_comb begin
    flag_d = flags_q[3];
    if (wr && idx == IDX_PERIPH_FLAGS) begin
      flag_d = PWDATA[FLAG_CONV];
    end
    if (finish) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      go_q    <= CTL0_RST[CTL0_GO];
      flags_q <= {FLAGS_RST[FLAG_CONV], FLAGS_RST[2:0]};
    end else if (CE) begin
      go_q       <= go_d;
      flags_q[3] <= flag_d;
      if (wr && idx == IDX_PERIPH_FLAGS) begin
        flags_q[2:0] <= PWDATA[2:0];
      end
    end
  end

  // Timer clear follows every trigger in mode 1011, powered or not
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      timer_clr_q <= 1'b0;
    end else if (CE) begin
      timer_clr_q <= SPECIAL_EVENT && (CAPCOMP_MODE == CAPCOMP_ADC_TRIG);
    end
  end

  // ---------------------------------------------------------------------------
  // Conversion clock: one tick per half period
  // ---------------------------------------------------------------------------
  always_comb begin
    case (clk_sel_q)
      SEL_2TOSC:  half_sel = HALF_2TOSC;
      SEL_8TOSC:  half_sel = HALF_8TOSC;
      SEL_32TOSC: half_sel = HALF_32TOSC;
      default:    half_sel = HALF_RC;
    endcase
  end

  assign tick    = (st_q == ST_CONV) && (div_q == half_q - 8'h01);
  assign resolve = tick && !hc_q[0] && (hc_q >= FIRST_RESOLVE) && (hc_q <= LAST_RESOLVE);
  assign finish  = tick && (hc_q == CONV_HALVES - 5'h01);

  // ---------------------------------------------------------------------------
  // Sequencer; the period is latched at start so a mid-run select write is harmless
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st_q   <= ST_IDLE;
      div_q  <= 8'h00;
      half_q <= HALF_2TOSC;
      hc_q   <= 5'h00;
      sar_q  <= 8'h00;
      mask_q <= 8'h00;
    end else if (CE) begin
      case (st_q)
        ST_IDLE: begin
          div_q <= 8'h00;
          hc_q  <= 5'h00;
          if (go_q) begin
            st_q   <= ST_CONV;
            half_q <= half_sel;
            sar_q  <= MSB_TRIAL;
            mask_q <= MSB_TRIAL;
          end
        end
        ST_CONV: begin
          div_q <= tick ? 8'h00 : div_q + 8'h01;
          if (tick) begin
            hc_q <= hc_q + 5'h01;
          end
          if (resolve) begin
            sar_q  <= (CMP_ABOVE ? sar_q : (sar_q & ~mask_q)) | (mask_q >> 1);
            mask_q <= mask_q >> 1;
          end
          if (finish || !go_q) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Result keeps its content through reset; unknown until the first conversion ends
  always_ff @(posedge CLK_SYS) begin
    if (CE && finish) begin
      result_q <= sar_q;
    end
  end

  // Marks a loaded result, so the hold check never compares unknown contents
  logic result_seen_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      result_seen_q <= 1'b0;
    end else if (CE && finish) begin
      result_seen_q <= 1'b1;
    end
  end

  // Output flops; the channel mux takes the pin whatever its direction
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      CHANNEL_SEL <= 3'h0;
      SAMPLE_HOLD <= 1'b0;
    end else if (CE) begin
      CHANNEL_SEL <= chan_q;
      SAMPLE_HOLD <= (st_q == ST_CONV) || go_q;
    end
  end

  assign PRDATA       = prdata_q;
  assign PREADY       = pready_q;
  assign PSLVERR      = pslverr_q;
  assign PORT_A_OUT   = latch_q;
  assign PORT_A_OE    = oe_q;
  assign DAC_CODE     = sar_q;
  assign CONV_BUSY    = go_q;
  assign TIMER1_CLEAR = timer_clr_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [11:0] cyc_q;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || st_q == ST_IDLE) begin
      cyc_q <= 12'h000;
    end else if (CE) begin
      cyc_q <= cyc_q + 12'h001;
    end
  end

  sequence s_finish;
    CE && finish;
  endsequence

  sequence s_launch;
    CE && st_q == ST_IDLE && go_q;
  endsequence

  property p_done;
    @(posedge CLK_SYS) disable iff (!RSTN)
    s_finish |=> (!go_q && flags_q[3] && result_q == $past(sar_q) && st_q == ST_IDLE);
  endproperty
  a_done: assert property (p_done) else $error("completion effects missing");

  property p_length;
    @(posedge CLK_SYS) disable iff (!RSTN)
    s_finish |-> (32'(cyc_q) + 32'd1 == 32'(CONV_HALVES) * 32'(half_q));
  endproperty
  a_length: assert property (p_length) else $error("conversion length wrong");

  property p_period;
    @(posedge CLK_SYS) disable iff (!RSTN)
    s_launch |=> half_q == (($past(clk_sel_q) == 2'h0) ? 8'd1 :
                            ($past(clk_sel_q) == 2'h1) ? 8'd4 :
                            ($past(clk_sel_q) == 2'h2) ? 8'd16 : 8'd200);
  endproperty
  a_period: assert property (p_period) else $error("period select wrong");

  property p_trig_on;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (CE && SPECIAL_EVENT && CAPCOMP_MODE == 4'hB && power_q) |=> (go_q && TIMER1_CLEAR);
  endproperty
  a_trig_on: assert property (p_trig_on) else $error("trigger did not start");

  property p_trig_off;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (CE && SPECIAL_EVENT && CAPCOMP_MODE == 4'hB && !power_q && !go_q && !wr)
      |=> (!go_q && TIMER1_CLEAR);
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("unpowered trigger acted");

  property p_analog_zero;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (CE && setup_acc && !PWRITE && aligned && idx == IDX_PORT_A_PINS)
      |=> ((PRDATA[ANALOG_W-1:0] & $past(analog_mask)) == 4'h0);
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin read high");

  property p_msb_first;
    @(posedge CLK_SYS) disable iff (!RSTN)
    s_launch |=> (DAC_CODE == 8'h80 && st_q == ST_CONV) ##1 (DAC_CODE[6:0] == 7'h00);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("trial not msb first");

  property p_result_hold;
    @(posedge CLK_SYS) disable iff (!RSTN)
    (CE && !finish && result_seen_q) |=> $stable(result_q);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed early");

  property p_no_block;
    @(posedge CLK_SYS) disable iff (!RSTN)
    s_launch |=> st_q == ST_CONV;
  endproperty
  a_no_block: assert property (p_no_block) else $error("conversion blocked");

endmodule // adc_conversion_control
`default_nettype wire

// *** testbench/adc_analog_model.sv ***
// Analog front end model: pin levels, driven pins, comparator, digital pin sampling
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model
  import adc_ctrl_pkg::*;
(
  input  wire logic [2:0]        chan,
  input  wire logic [7:0]        dac,
  input  wire logic [PORT_W-1:0] port_out,
  input  wire logic [PORT_W-1:0] port_oe,
  input  wire logic [39:0]       levels,
  output logic                   cmp_above,
  output logic      [PORT_W-1:0] pins
);
  logic [7:0] lvl [PORT_W];
  logic [7:0] sel_lvl;

  // ---------------------------------------------------------------------------
  // Pin levels and ideal comparator
  // ---------------------------------------------------------------------------
  // A driven pin shows its own output level; missing channels sit at ground
  always_comb begin
    sel_lvl = 8'h00;
    for (int i = 0; i < PORT_W; i++) begin
      lvl[i] = port_oe[i] ? {8{port_out[i]}} : levels[8*i +: 8];
      pins[i] = lvl[i][7];
      if (chan == 3'(i)) begin
        sel_lvl = lvl[i];
      end
    end
    cmp_above = (sel_lvl >= dac);
  end
endmodule // adc_analog_model
`default_nettype wire

// *** testbench/test_adc_conversion_control.sv ***
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_control;
  import adc_ctrl_pkg::*;
  logic                CLK_SYS, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic                SPECIAL_EVENT, CMP_ABOVE, SAMPLE_HOLD, CONV_BUSY, TIMER1_CLEAR;
  logic [11:0]         PADDR;
  logic [31:0]         PWDATA, PRDATA;
  logic [PORT_W-1:0]   PORT_A_IN, PORT_A_OUT, PORT_A_OE;
  logic [3:0]          CAPCOMP_MODE;
  logic [2:0]          CHANNEL_SEL;
  logic [7:0]          DAC_CODE;
  logic [39:0]         levels;
  int                  fails, n_tests;
  localparam logic [31:0] VALS = 32'hC12D99A5;

  adc_conversion_control dut (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(1'b1), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PORT_A_IN(PORT_A_IN), .PORT_A_OUT(PORT_A_OUT),
    .PORT_A_OE(PORT_A_OE), .CAPCOMP_MODE(CAPCOMP_MODE), .SPECIAL_EVENT(SPECIAL_EVENT),
    .CMP_ABOVE(CMP_ABOVE), .CHANNEL_SEL(CHANNEL_SEL), .DAC_CODE(DAC_CODE),
    .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_BUSY(CONV_BUSY), .TIMER1_CLEAR(TIMER1_CLEAR));

  adc_analog_model afe (.chan(CHANNEL_SEL), .dac(DAC_CODE), .port_out(PORT_A_OUT),
    .port_oe(PORT_A_OE), .levels(levels), .cmp_above(CMP_ABOVE), .pins(PORT_A_IN));

  // ---------------------------------------------------------------------------
  // Clock, reporting and bus tasks
  // ---------------------------------------------------------------------------
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      fails++;
    end
  endtask

  // Request held until PREADY is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] ix, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge CLK_SYS);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= wr;
    PADDR <= {2'b00, ix, 2'b00}; PWDATA <= {24'h0, wd};
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      conclude();
    end
    rd = PRDATA; er = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ix, input logic [7:0] wd);
    logic [31:0] rd;
    logic er;
    apb(1'b1, ix, wd, rd, er);
  endtask

  task automatic rdc(input string nm, input logic [7:0] ix, input logic [31:0] exp);
    logic [31:0] rd;
    logic er;
    apb(1'b0, ix, 8'h00, rd, er);
    chk(nm, exp, rd);
  endtask

  // Counts cycles with the busy bit up; the bound stands in for a hang
  task automatic wait_idle(output int n);
    n = 0;
    while (CONV_BUSY === 1'b1 && n < 5000) begin
      @(posedge CLK_SYS); #1;
      n++;
    end
    if (n >= 5000) begin
      fails++;
      conclude();
    end
  endtask

  // Channel picked in a write of its own before the start bit; power already on
  task automatic conv(input logic [1:0] s, input logic [2:0] ch, output int n);
    wr(IDX_CONV_CTRL0, {s, ch, 3'b001});
    wr(IDX_CONV_CTRL0, {s, ch, 3'b101});
    #1;
    wait_idle(n);
  endtask

  task automatic trig(input logic [3:0] m, output logic tc, output logic bz);
    @(posedge CLK_SYS);
    CAPCOMP_MODE <= m; SPECIAL_EVENT <= 1'b1;
    @(posedge CLK_SYS);
    SPECIAL_EVENT <= 1'b0;
    #1 tc = TIMER1_CLEAR; bz = CONV_BUSY;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] rd;
    logic er;
    rdc("control0", IDX_CONV_CTRL0, CTL0_RST);
    rdc("control1", IDX_CONV_CTRL1, CTL1_RST);
    rdc("direction", IDX_PORT_A_DIR, DIR_RST);
    rdc("flags", IDX_PERIPH_FLAGS, FLAGS_RST);
    apb(1'b0, 8'h40, 8'h00, rd, er);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    $display("test reset done");
  endtask

  task automatic t_port;
    @(posedge CLK_SYS) levels <= '1;
    rdc("port analog", IDX_PORT_A_PINS, 32'h10);
    wr(IDX_CONV_CTRL1, 8'h06);
    rdc("port digital", IDX_PORT_A_PINS, 32'h1F);
    $display("test port done");
  endtask

  // Every clock select; interrupt armed after the flag is cleared
  task automatic t_clock;
    int n, h;
    wr(IDX_CONV_CTRL0, 8'h01);
    wr(IDX_PERIPH_FLAGS, 8'h00);
    wr(IDX_PERIPH_ENABLE, 8'h40);
    wr(IDX_INTR_CONTROL, 8'h80);
    rdc("enable", IDX_PERIPH_ENABLE, 32'h40);
    rdc("int control", IDX_INTR_CONTROL, 32'h80);
    for (int s = 0; s < 4; s++) begin
      h = (s == 3) ? 200 : (1 << (2 * s));
      @(posedge CLK_SYS) levels[15:8] <= VALS[8*s +: 8];
      conv(2'(s), 3'd1, n);
      chk("busy cycles", 32'(19 * h + 1), 32'(n));
      rdc("result", IDX_CONV_RESULT, {24'h0, VALS[8*s +: 8]});
      rdc("go cleared", IDX_CONV_CTRL0, {24'h0, 2'(s), 6'b001001});
      rdc("flag set", IDX_PERIPH_FLAGS, 32'h40);
      wr(IDX_PERIPH_FLAGS, 8'h00);
      repeat (4 * h) @(posedge CLK_SYS);
    end
    $display("test clock done");
  endtask

  task automatic t_pins;
    int n;
    wr(IDX_PORT_A_DIR, 8'h1B);
    wr(IDX_PORT_A_PINS, 8'h04);
    @(posedge CLK_SYS) levels[23:16] <= 8'h33;
    conv(2'd0, 3'd2, n);
    rdc("driven high", IDX_CONV_RESULT, 32'hFF);
    wr(IDX_PORT_A_PINS, 8'h00);
    conv(2'd0, 3'd2, n);
    rdc("driven low", IDX_CONV_RESULT, 32'h00);
    wr(IDX_PORT_A_DIR, 8'h1F);
    @(posedge CLK_SYS) levels[7:0] <= 8'h47;
    conv(2'd0, 3'd0, n);
    rdc("digital input", IDX_CONV_RESULT, 32'h47);
    conv(2'd0, 3'd5, n);
    chk("no pin cycles", 32'd20, 32'(n));
    rdc("no pin result", IDX_CONV_RESULT, 32'h00);
    $display("test pins done");
  endtask

  task automatic t_trig;
    logic tc, bz;
    int n;
    wr(IDX_CONV_CTRL0, 8'h01);
    @(posedge CLK_SYS) levels[7:0] <= 8'h5A;
    trig(CAPCOMP_ADC_TRIG, tc, bz);
    chk("timer clear", 32'h1, {31'h0, tc});
    chk("trigger start", 32'h1, {31'h0, bz});
    @(posedge CLK_SYS);
    #1 chk("sample hold", 32'h1, {31'h0, SAMPLE_HOLD});
    wait_idle(n);
    rdc("trigger result", IDX_CONV_RESULT, 32'h5A);
    wr(IDX_CONV_CTRL0, 8'h00);
    trig(CAPCOMP_ADC_TRIG, tc, bz);
    chk("off timer clear", 32'h1, {31'h0, tc});
    chk("off no start", 32'h0, {31'h0, bz});
    wr(IDX_CONV_CTRL0, 8'h01);
    trig(4'h3, tc, bz);
    chk("mode timer", 32'h0, {31'h0, tc});
    chk("mode no start", 32'h0, {31'h0, bz});
    $display("test trigger done");
  endtask

  // A second reset keeps the last result while the controls return to reset
  task automatic t_rst;
    @(posedge CLK_SYS) RSTN <= 1'b0;
    repeat (16) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    rdc("result kept", IDX_CONV_RESULT, 32'h5A);
    rdc("control0 again", IDX_CONV_CTRL0, CTL0_RST);
    $display("test second reset done");
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    RSTN = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
    PADDR = 12'h000; PWDATA = 32'h0; CAPCOMP_MODE = 4'h0;
    SPECIAL_EVENT = 1'b0; levels = '1; fails = 0; n_tests = 0;
    repeat (16) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    t_reset();
    t_port();
    t_clock();
    t_pins();
    t_trig();
    t_rst();
    conclude();
  end
endmodule // test_adc_conversion_control
`default_nettype wire
